// ### bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bit_shift_flag_pkg::*;

	typedef struct packed {
		logic [15:0] cmd;
		logic [15:0] mem;
		logic [7:0] opnd;
		logic [7:0] io;
		logic [7:0] flg;
		logic [7:0] eOpnd;
		logic [7:0] eIo;
		logic [7:0] eFlg;
		logic [3:0] eCyc;
		logic [2:0] eEvt;
	} row_t;

	logic sys_clk;
	logic reset;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic nvmBusy;
	core_evt_t coreEvt;
	logic busy;
	int n_fail;
	int checks;
	int n;
	logic [2:0] evt;
	logic [31:0] d;

	// Command, mem addr, opnd, io, flags, then expected opnd, io, flags, cycles, events
	row_t rows [29] = '{
		'{16'h0001, 16'h0000, 8'h88, 8'h00, 8'h00, 8'h10, 8'h00, 8'h39, 4'h1, 3'h0},
		'{16'h0002, 16'h0000, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1B, 4'h1, 3'h0},
		'{16'h0003, 16'h0000, 8'h80, 8'h00, 8'h41, 8'h01, 8'h00, 8'h59, 4'h1, 3'h0},
		'{16'h0004, 16'h0000, 8'h02, 8'h00, 8'h21, 8'h81, 8'h00, 8'h2C, 4'h1, 3'h0},
		'{16'h0005, 16'h0000, 8'h81, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h15, 4'h1, 3'h0},
		'{16'h0006, 16'h0000, 8'hA5, 8'h00, 8'hFF, 8'h5A, 8'h00, 8'hFF, 4'h1, 3'h0},
		'{16'h0207, 16'h0000, 8'h33, 8'h00, 8'hAA, 8'h33, 8'h04, 8'hAA, 4'h2, 3'h0},
		'{16'h0708, 16'h0000, 8'h33, 8'hFF, 8'h55, 8'h33, 8'h7F, 8'h55, 4'h2, 3'h0},
		'{16'h0309, 16'h0000, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00, 8'h40, 4'h1, 3'h0},
		'{16'h0309, 16'h0000, 8'hF7, 8'h00, 8'hFF, 8'hF7, 8'h00, 8'hBF, 4'h1, 3'h0},
		'{16'h070A, 16'h0000, 8'h00, 8'h00, 8'h40, 8'h80, 8'h00, 8'h40, 4'h1, 3'h0},
		'{16'h000A, 16'h0000, 8'hFF, 8'h00, 8'hBF, 8'hFE, 8'h00, 8'hBF, 4'h1, 3'h0},
		'{16'h070B, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 4'h1, 3'h0},
		'{16'h000C, 16'h0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFE, 4'h1, 3'h0},
		'{16'h000D, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 4'h1, 3'h0},
		'{16'h000E, 16'h0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hF7, 4'h1, 3'h0},
		'{16'h000F, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 4'h1, 3'h0},
		'{16'h0010, 16'h0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hDF, 4'h1, 3'h0},
		'{16'h0011, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 4'h1, 3'h0},
		'{16'h0012, 16'h0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hEF, 4'h1, 3'h0},
		'{16'h0013, 16'h0000, 8'h5A, 8'hC3, 8'h5A, 8'h5A, 8'hC3, 8'h5A, 4'h1, 3'h4},
		'{16'h0014, 16'h0000, 8'h5A, 8'hC3, 8'hA5, 8'h5A, 8'hC3, 8'hA5, 4'h1, 3'h2},
		'{16'h0015, 16'h0000, 8'h5A, 8'hC3, 8'h3C, 8'h5A, 8'hC3, 8'h3C, 4'h1, 3'h1},
		'{16'h4016, 16'h0020, 8'h5A, 8'hC3, 8'h00, 8'h5A, 8'hC3, 8'h00, 4'h3, 3'h0},
		'{16'h0016, 16'h0060, 8'h5A, 8'hC3, 8'h00, 8'h5A, 8'hC3, 8'h00, 4'h1, 3'h0},
		'{16'hA016, 16'h005F, 8'h5A, 8'hC3, 8'h00, 8'h5A, 8'hC3, 8'h00, 4'h3, 3'h0},
		'{16'h6016, 16'h001F, 8'h5A, 8'hC3, 8'h00, 8'h5A, 8'hC3, 8'h00, 4'h3, 3'h0},
		'{16'h4016, 16'h0060, 8'h5A, 8'hC3, 8'h00, 8'h5A, 8'hC3, 8'h00, 4'h2, 3'h0},
		'{16'h2016, 16'h005F, 8'h5A, 8'hC3, 8'h00, 8'h5A, 8'hC3, 8'h00, 4'h2, 3'h0}
	};

	bit_shift_flag_unit i_dut (
		.sys_clk(sys_clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.nvmBusy(nvmBusy),
		.coreEvt(coreEvt),
		.busy(busy)
	);

	////////////////////////////////////////////////////////////////
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, addr};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wdata;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
		logic [31:0] unused;
		bus(1'b1, addr, wdata, unused);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] got;
		bus(1'b0, addr, 32'h0, got);
		chk(got, exp);
	endtask

	// Busy span counted from the edge that ends the command write
	task automatic exec(input row_t r, output int cyc, output logic [2:0] ev);
		wr(OFF_OPND, {24'hFFFFFF, r.opnd});
		wr(OFF_IODATA, {24'hFFFFFF, r.io});
		wr(OFF_STATUS_FLAGS, {24'hFFFFFF, r.flg});
		wr(OFF_MEMADDR, {16'h0, r.mem});
		wr(OFF_CMD, {16'h0, r.cmd});
		cyc = 0;
		while (busy === 1'b1 && cyc < 64) begin
			@(posedge sys_clk);
			cyc++;
		end
		ev = coreEvt;
	endtask

	task automatic end_of_test;
		$display("Mismatches %0d, comparisons %0d", n_fail, checks);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		#100000;
		n_fail++;
		end_of_test;
	end

	initial begin
		n_fail = 0;
		checks = 0;
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		nvmBusy = 1'b0;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		chk({29'h0, hreadyout, busy, hresp}, 32'h4);
		for (int a = 0; a < 8; a++)
			rdChk(8'(a * 4), 32'h0);
		wr(OFF_STAT, 32'hFFFFFFFF);
		wr(8'h18, 32'hFFFFFFFF);
		rdChk(OFF_STAT, 32'h0);
		rdChk(8'h18, 32'h0);
		foreach (rows[i]) begin
			exec(rows[i], n, evt);
			chk(32'(n), {28'h0, rows[i].eCyc});
			chk({29'h0, evt}, {29'h0, rows[i].eEvt});
			rdChk(OFF_OPND, {24'h0, rows[i].eOpnd});
			rdChk(OFF_IODATA, {24'h0, rows[i].eIo});
			rdChk(OFF_STATUS_FLAGS, {24'h0, rows[i].eFlg});
			rdChk(OFF_STAT, {20'h0, rows[i].eCyc, 8'h0});
		end
		// Controller stall holds busy; writes meanwhile are dropped
		@(posedge sys_clk);
		nvmBusy <= 1'b1;
		wr(OFF_OPND, 32'h5A);
		wr(OFF_MEMADDR, 32'h60);
		wr(OFF_CMD, 32'hA016);
		wr(OFF_CMD, 32'h0006);
		wr(OFF_OPND, 32'h11);
		bus(1'b0, OFF_STAT, 32'h0, d);
		chk({31'h0, d[0]}, 32'h1);
		@(posedge sys_clk);
		nvmBusy <= 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 64) begin
			@(posedge sys_clk);
			n++;
		end
		chk({31'h0, busy}, 32'h0);
		rdChk(OFF_OPND, 32'h5A);
		// Second reset in the middle of a stalled access
		@(posedge sys_clk);
		nvmBusy <= 1'b1;
		wr(OFF_CMD, 32'hA016);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		nvmBusy <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk({30'h0, busy, coreEvt.sleepReq}, 32'h0);
		rdChk(OFF_OPND, 32'h0);
		rdChk(OFF_STAT, 32'h0);
		end_of_test;
	end

endmodule

// ### rtl/bit_shift_flag_pkg.sv
package bit_shift_flag_pkg;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_OPND = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IODATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS_FLAGS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_MEMADDR = 8'h14;

	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam logic [7:0] MASK_V = 8'h08;
	localparam logic [7:0] MASK_S = 8'h10;
	localparam logic [7:0] MASK_H = 8'h20;
	localparam logic [7:0] MASK_T = 8'h40;

	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] MEMADDR_RESET = 16'h0000;
	localparam logic [15:0] IO_LOW_FIRST = 16'h0020;
	localparam logic [15:0] IO_LOW_LAST = 16'h005F;

	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_IO_BIT = 4'h2;
	localparam logic [3:0] CYC_NVM_MIN = 4'h1;
	localparam logic [3:0] CYC_LOW_IO = 4'h1;
	localparam logic [3:0] CYC_NONE = 4'h0;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_LSL = 5'h01,
		OP_LSR = 5'h02,
		OP_ROL = 5'h03,
		OP_ROR = 5'h04,
		OP_ASR = 5'h05,
		OP_SWAP = 5'h06,
		OP_IO_SET = 5'h07,
		OP_IO_CLR = 5'h08,
		OP_BIT_TO_FLAG = 5'h09,
		OP_FLAG_TO_BIT = 5'h0A,
		OP_STATUS_FLAGS_REGISTER_SET = 5'h0B,
		OP_STATUS_FLAGS_REGISTER_CLR = 5'h0C,
		OP_OV_SET = 5'h0D,
		OP_OV_CLR = 5'h0E,
		OP_HC_SET = 5'h0F,
		OP_HC_CLR = 5'h10,
		OP_SIGN_SET = 5'h11,
		OP_SIGN_CLR = 5'h12,
		OP_BREAK = 5'h13,
		OP_SLEEP = 5'h14,
		OP_WDT_RESTART = 5'h15,
		OP_MEM_ACC = 5'h16
	} op_t;

	typedef struct packed {
		logic [15:0] rsvdHi;
		logic nvm;
		logic [1:0] memBase;
		logic [1:0] rsvdMid;
		logic [2:0] bitSel;
		logic [2:0] rsvdLo;
		op_t op;
	} cmd_t;

	typedef struct packed {
		logic [19:0] rsvdHi;
		logic [3:0] lastCycles;
		logic [6:0] rsvdLo;
		logic busy;
	} stat_t;

	typedef struct packed {
		logic breakReq;
		logic sleepReq;
		logic wdtRestart;
	} core_evt_t;

endpackage

// ### rtl/bit_shift_flag_unit.sv
// Summary of operation
// - Rotate left through carry, flags, one cycle
// - Rotate right through carry, flags, one cycle
// - I/O bit set, flags kept, two cycles
// - I/O bit clear, flags kept, two cycles
// - Register bit copied into transfer flag
// - Transfer flag written into register bit
// - Overflow set/clear touches only overflow
// - Half-carry set/clear touches only half-carry
// - Signed flag set/clear touches only it
// - Break: one cycle, no flags, debug request
// - Sleep: one cycle, no flags, sleep request
// - Watchdog restart: one cycle, restart pulse
// - Listed memory counts hold for internal RAM
// - Controller memory access adds cycles, waits busy
// - Low 64-byte I/O access adds one cycle
module bit_shift_flag_unit (
	input wire logic sys_clk, // Core clock
	input wire logic reset, // Synchronous reset
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write strobe
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic nvmBusy, // Memory controller busy pin
	output bit_shift_flag_pkg::core_evt_t coreEvt, // Break/sleep/watchdog pulses
	output logic busy // Operation in progress
);
	import bit_shift_flag_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NVM_WAIT} state_t;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave

	logic dataPhQ, wrQ;
	logic [ADDR_W-1:0] addrQ;
	logic [7:0] opndQ, ioQ, sregQ;
	logic [15:0] memAddrQ;
	logic [3:0] cntQ, cycQ, lastCycQ;
	cmd_t cmdQ;
	state_t stQ;
	logic nvmMetaQ, nvmSyncQ;
	stat_t statWord;

	wire addrPhase = hsel && htrans[1] && hready;
	wire idle = (stQ == ST_IDLE);
	wire wrAny = dataPhQ && wrQ && idle;
	wire wrCmd = wrAny && (addrQ == OFF_CMD);
	wire wrOpnd = wrAny && (addrQ == OFF_OPND);
	wire wrIo = wrAny && (addrQ == OFF_IODATA);
	wire wrSreg = wrAny && (addrQ == OFF_STATUS_FLAGS);
	wire wrMem = wrAny && (addrQ == OFF_MEMADDR);

	assign statWord = '{rsvdHi: '0, lastCycles: lastCycQ, rsvdLo: '0, busy: busy};
	wire [31:0] rdMux = (addrQ == OFF_CMD) ? 32'(cmdQ) :
		(addrQ == OFF_OPND) ? {24'h000000, opndQ} :
		(addrQ == OFF_IODATA) ? {24'h000000, ioQ} :
		(addrQ == OFF_STATUS_FLAGS) ? {24'h000000, sregQ} :
		(addrQ == OFF_STAT) ? 32'(statWord) :
		(addrQ == OFF_MEMADDR) ? {16'h0000, memAddrQ} : 32'h00000000;

	// One wait state per transfer so read data leaves a flop
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dataPhQ <= 1'b0;
			wrQ <= 1'b0;
			addrQ <= '0;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else begin
			dataPhQ <= addrPhase;
			hreadyout <= !addrPhase;
			hresp <= 1'b0;
			if (addrPhase) begin
				wrQ <= hwrite;
				addrQ <= haddr[ADDR_W-1:0];
			end
			if (dataPhQ && !wrQ) begin
				hrdata <= rdMux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cycle budget of a new command

	cmd_t newCmd;
	assign newCmd = cmd_t'(hwdata);
	wire newMem = (newCmd.op == OP_MEM_ACC);
	wire newIoBit = (newCmd.op == OP_IO_SET) || (newCmd.op == OP_IO_CLR);
	wire lowIo = newMem && (memAddrQ >= IO_LOW_FIRST) && (memAddrQ <= IO_LOW_LAST);
	wire [3:0] memBase = (newCmd.memBase == 2'b00) ? CYC_ONE : {2'b00, newCmd.memBase};
	wire [3:0] baseCyc = newIoBit ? CYC_IO_BIT : (newMem ? memBase : CYC_ONE);
	wire [3:0] lowExtra = lowIo ? CYC_LOW_IO : CYC_NONE;
	wire [3:0] nvmExtra = (newMem && newCmd.nvm) ? CYC_NVM_MIN : CYC_NONE;
	wire [3:0] needCyc = baseCyc + lowExtra + nvmExtra;

	wire needWait = (cmdQ.op == OP_MEM_ACC) && cmdQ.nvm && nvmSyncQ;
	wire commit = ((stQ == ST_EXEC) && (cntQ == 4'h0) && !needWait) ||
		((stQ == ST_NVM_WAIT) && !nvmSyncQ);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nvmMetaQ <= 1'b0;
			nvmSyncQ <= 1'b0;
		end else begin
			nvmMetaQ <= nvmBusy;
			nvmSyncQ <= nvmMetaQ;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stQ <= ST_IDLE;
			cmdQ <= '0;
			cntQ <= 4'h0;
			cycQ <= 4'h0;
			lastCycQ <= 4'h0;
			busy <= 1'b0;
		end else begin
			case (stQ)
				ST_IDLE: begin
					if (wrCmd) begin
						cmdQ <= newCmd;
						cntQ <= needCyc - CYC_ONE;
						cycQ <= CYC_ONE;
						busy <= 1'b1;
						stQ <= ST_EXEC;
					end
				end
				ST_EXEC, ST_NVM_WAIT: begin
					if (commit) begin
						lastCycQ <= cycQ;
						busy <= 1'b0;
						stQ <= ST_IDLE;
					end else begin
						cycQ <= cycQ + CYC_ONE;
						if (cntQ != 4'h0) begin
							cntQ <= cntQ - CYC_ONE;
						end else begin
							stQ <= ST_NVM_WAIT;
						end
					end
				end
				default: stQ <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath

	logic [7:0] resD, ioD, sregD, shf;
	logic cOut, isShift, hUpd;

	always_comb begin
		resD = opndQ;
		ioD = ioQ;
		sregD = sregQ;
		shf = opndQ;
		cOut = sregQ[FLAG_C];
		isShift = 1'b0;
		hUpd = 1'b0;
		case (cmdQ.op)
			OP_LSL: begin
				shf = {opndQ[6:0], 1'b0};
				cOut = opndQ[7];
				isShift = 1'b1;
				hUpd = 1'b1;
			end
			OP_LSR: begin
				shf = {1'b0, opndQ[7:1]};
				cOut = opndQ[0];
				isShift = 1'b1;
			end
			OP_ROL: begin
				shf = {opndQ[6:0], sregQ[FLAG_C]};
				cOut = opndQ[7];
				isShift = 1'b1;
				hUpd = 1'b1;
			end
			OP_ROR: begin
				shf = {sregQ[FLAG_C], opndQ[7:1]};
				cOut = opndQ[0];
				isShift = 1'b1;
			end
			OP_ASR: begin
				shf = {opndQ[7], opndQ[7:1]};
				cOut = opndQ[0];
				isShift = 1'b1;
			end
			OP_SWAP: resD = {opndQ[3:0], opndQ[7:4]};
			OP_IO_SET: ioD[cmdQ.bitSel] = 1'b1;
			OP_IO_CLR: ioD[cmdQ.bitSel] = 1'b0;
			OP_BIT_TO_FLAG: sregD[FLAG_T] = opndQ[cmdQ.bitSel];
			OP_FLAG_TO_BIT: resD[cmdQ.bitSel] = sregQ[FLAG_T];
			OP_STATUS_FLAGS_REGISTER_SET: sregD[cmdQ.bitSel] = 1'b1;
			OP_STATUS_FLAGS_REGISTER_CLR: sregD[cmdQ.bitSel] = 1'b0;
			OP_OV_SET: sregD[FLAG_V] = 1'b1;
			OP_OV_CLR: sregD[FLAG_V] = 1'b0;
			OP_HC_SET: sregD[FLAG_H] = 1'b1;
			OP_HC_CLR: sregD[FLAG_H] = 1'b0;
			OP_SIGN_SET: sregD[FLAG_S] = 1'b1;
			OP_SIGN_CLR: sregD[FLAG_S] = 1'b0;
			default: ;
		endcase
		if (isShift) begin
			resD = shf;
			sregD[FLAG_C] = cOut;
			sregD[FLAG_N] = shf[7];
			sregD[FLAG_Z] = (shf == 8'h00);
			sregD[FLAG_V] = shf[7] ^ cOut;
			sregD[FLAG_S] = cOut;
			if (hUpd) begin
				sregD[FLAG_H] = opndQ[3];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			opndQ <= BYTE_RESET;
			ioQ <= BYTE_RESET;
			sregQ <= BYTE_RESET;
			memAddrQ <= MEMADDR_RESET;
			coreEvt <= '0;
		end else begin
			if (commit) begin
				opndQ <= resD;
				ioQ <= ioD;
				sregQ <= sregD;
			end else begin
				if (wrOpnd) opndQ <= hwdata[7:0];
				if (wrIo) ioQ <= hwdata[7:0];
				if (wrSreg) sregQ <= hwdata[7:0];
			end
			if (wrMem) memAddrQ <= hwdata[15:0];
			coreEvt.breakReq <= commit && (cmdQ.op == OP_BREAK);
			coreEvt.sleepReq <= commit && (cmdQ.op == OP_SLEEP);
			coreEvt.wdtRestart <= commit && (cmdQ.op == OP_WDT_RESTART);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [7:0] prevOpndQ, prevSregQ;
	always_ff @(posedge sys_clk) begin
		prevOpndQ <= opndQ;
		prevSregQ <= sregQ;
	end
	wire [7:0] sregDiff = sregQ ^ prevSregQ;
	wire done = commit;
	op_t op;
	assign op = cmdQ.op;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence sOneCycle;
		busy ##1 !busy;
	endsequence
	sequence sTwoCycles;
		busy [*2] ##1 !busy;
	endsequence

	AST_ROL_RESULT: assert property (done && op == OP_ROL |=>
		opndQ == {prevOpndQ[6:0], prevSregQ[FLAG_C]} && sregQ[FLAG_C] == prevOpndQ[7]
		&& sregQ[FLAG_H] == prevOpndQ[3]) else $error("rotate left wrong");
	AST_ROR_RESULT: assert property (done && op == OP_ROR |=>
		opndQ == {prevSregQ[FLAG_C], prevOpndQ[7:1]} && sregQ[FLAG_C] == prevOpndQ[0]
		&& sregQ[FLAG_Z] == (opndQ == 8'h00)) else $error("rotate right wrong");
	AST_SINGLE_CYCLE: assert property (wrCmd && !newIoBit && !newMem |=> sOneCycle)
		else $error("single-cycle op length wrong");
	AST_IO_SET_TWO: assert property (wrCmd && newCmd.op == OP_IO_SET |=> sTwoCycles
		##0 (ioQ[cmdQ.bitSel] && sregQ == $past(sregQ, 3))) else $error("io set wrong");
	AST_IO_CLR_TWO: assert property (wrCmd && newCmd.op == OP_IO_CLR |=> sTwoCycles
		##0 (!ioQ[cmdQ.bitSel] && sregQ == $past(sregQ, 3))) else $error("io clear wrong");
	AST_BIT_TO_FLAG: assert property (done && op == OP_BIT_TO_FLAG |=>
		sregQ[FLAG_T] == prevOpndQ[cmdQ.bitSel] && (sregDiff & ~MASK_T) == 8'h00)
		else $error("bit to flag wrong");
	AST_FLAG_TO_BIT: assert property (done && op == OP_FLAG_TO_BIT |=>
		opndQ[cmdQ.bitSel] == prevSregQ[FLAG_T] && sregDiff == 8'h00)
		else $error("flag to bit wrong");
	AST_OV_ONLY: assert property (done && (op == OP_OV_SET || op == OP_OV_CLR) |=>
		sregQ[FLAG_V] == (op == OP_OV_SET) && (sregDiff & ~MASK_V) == 8'h00)
		else $error("overflow op wrong");
	AST_HC_ONLY: assert property (done && (op == OP_HC_SET || op == OP_HC_CLR) |=>
		sregQ[FLAG_H] == (op == OP_HC_SET) && (sregDiff & ~MASK_H) == 8'h00)
		else $error("half-carry op wrong");
	AST_SIGN_ONLY: assert property (done && (op == OP_SIGN_SET || op == OP_SIGN_CLR) |=>
		sregQ[FLAG_S] == (op == OP_SIGN_SET) && (sregDiff & ~MASK_S) == 8'h00)
		else $error("signed flag op wrong");
	AST_BREAK_PULSE: assert property (done && op == OP_BREAK |=>
		coreEvt.breakReq && sregDiff == 8'h00 ##1 !coreEvt.breakReq) else $error("break wrong");
	AST_SLEEP_PULSE: assert property (done && op == OP_SLEEP |=>
		coreEvt.sleepReq && sregDiff == 8'h00 ##1 !coreEvt.sleepReq) else $error("sleep wrong");
	AST_WDT_PULSE: assert property (coreEvt.wdtRestart |->
		$past(done) && op == OP_WDT_RESTART && sregDiff == 8'h00) else $error("watchdog wrong");
	AST_RAM_COUNT: assert property (wrCmd && newMem && !newCmd.nvm && !lowIo
		&& newCmd.memBase == 2'b10 |=> sTwoCycles) else $error("ram access length wrong");
	AST_NVM_EXTRA: assert property (wrCmd && newMem && newCmd.nvm && !lowIo
		&& newCmd.memBase == 2'b01 |=> busy [*2]) else $error("controller penalty missing");
	AST_LOW_IO_EXTRA: assert property (wrCmd && newMem && !newCmd.nvm && lowIo
		&& newCmd.memBase == 2'b01 |=> sTwoCycles) else $error("low io penalty wrong");
	AST_SHIFT_FILL: assert property (done && op == OP_LSR |=>
		!opndQ[7] && sregQ[FLAG_C] == prevOpndQ[0] && !sregQ[FLAG_N]) else $error("shift wrong");
	AST_ASR_SIGN: assert property (done && op == OP_ASR |=>
		opndQ[7] == prevOpndQ[7] && opndQ[6:0] == prevOpndQ[7:1]) else $error("asr wrong");
	AST_STATUS_FLAGS_REGISTER_BIT: assert property (done && op == OP_STATUS_FLAGS_REGISTER_SET |=>
		sregQ[cmdQ.bitSel] && (sregDiff & ~(8'h01 << cmdQ.bitSel)) == 8'h00)
		else $error("status bit set wrong");

endmodule
